// [pkg/bwd_defines.svh]
`ifndef BWD_DEFINES_SVH
`define BWD_DEFINES_SVH
// register numbers in processor status space
`define BWD_REG_IRQ_DATA 8'h16
`define BWD_REG_CORE_HOLD 8'h18
`define BWD_REG_SCRATCH 8'h20
`define BWD_REG_IBRK_ADDR 8'h30
`define BWD_REG_IBRK_CTRL 8'h40
`define BWD_REG_DW_ADDR1 8'h50
`define BWD_REG_DW_ADDR2 8'h60
`define BWD_REG_DW_CTRL 8'h70
`define BWD_REG_RW_MASK 8'h80
`define BWD_REG_RW_VALUE 8'h90
`define BWD_REG_RW_CTRL 8'h9c
`define BWD_REG_IRQ_TYPE 8'h15
// scratch words in tile configuration space
`define BWD_CFG_SCRATCH 8'h20
// control field positions
`define BWD_CTL_EN 0
`define BWD_CTL_SEL 1
`define BWD_CTL_LOAD 2
`define BWD_CTL_THR_LO 16
`define BWD_CTL_THR_HI 23
`define BWD_CTL_RST 32'h0000_0000
`define BWD_IBRK_CTL_MASK 32'h00ff_0003
`define BWD_DW_CTL_MASK 32'h00ff_0007
`define BWD_RW_CTL_MASK 32'h00ff_0003
`define BWD_HOLD_MASK 32'h0000_00ff
// cause codes
`define BWD_CAUSE_IBRK 3'h3
`define BWD_CAUSE_DW 3'h4
`define BWD_CAUSE_RW 3'h5
`endif

// [pkg/bwd_pkg.sv]
package bwd_pkg;
    typedef logic [31:0] bwd_word_t;
    typedef logic [2:0] bwd_cause_t;
    typedef enum logic [2:0] {
        BWD_HIT_NONE = 3'b001,
        BWD_HIT_CAPTURE = 3'b010,
        BWD_HIT_WAIT = 3'b100
    } bwd_hit_state_t;
endpackage : bwd_pkg

// [rtl/bwd_first_hit.sv]
`timescale 1ns/1ps
`default_nettype none
// lowest-numbered set request wins
module bwd_first_hit #(
    parameter int N = 4
) (
    input wire logic [N-1:0] req_in,
    output logic any_out,
    output logic [1:0] idx_out
);
    always_comb
    begin
        any_out = |req_in;
        idx_out = 2'h0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req_in[i])
            begin
                idx_out = i[1:0];
            end
        end
    end
endmodule : bwd_first_hit
`default_nettype wire

// [rtl/bwd_comparator.sv]
`timescale 1ns/1ps
`default_nettype none
// one comparator slot of each kind, per index
module bwd_comparator (
    input wire logic [31:0] ib_target_in,
    input wire logic [31:0] ib_ctrl_in,
    input wire logic [31:0] pc_in,
    input wire logic [31:0] dw_first_in,
    input wire logic [31:0] dw_second_in,
    input wire logic [31:0] dw_ctrl_in,
    input wire logic [31:0] ea_in,
    input wire logic is_load_in,
    input wire logic [31:0] rw_mask_in,
    input wire logic [31:0] rw_value_in,
    input wire logic [31:0] rw_ctrl_in,
    input wire logic [31:0] res_id_in,
    input wire logic [7:0] ib_thr_in,
    input wire logic [7:0] ls_thr_in,
    input wire logic [7:0] rs_thr_in,
    input wire logic pc_valid_in,
    input wire logic ls_valid_in,
    input wire logic rs_valid_in,
    output logic ib_hit_out,
    output logic dw_hit_out,
    output logic rw_hit_out
);
    `include "bwd_defines.svh"
    logic pc_eq;
    logic cond_a;
    logic cond_b;
    logic dw_cond;
    logic rw_a;
    logic rw_b;
    assign pc_eq = (pc_in == ib_target_in);
    // equal or not equal selection thread gate enable
    assign ib_hit_out = pc_valid_in && ib_ctrl_in[`BWD_CTL_EN]
        && |(ib_ctrl_in[`BWD_CTL_THR_HI:`BWD_CTL_THR_LO] & ib_thr_in)
        && (ib_ctrl_in[`BWD_CTL_SEL] ? !pc_eq : pc_eq);
    // address matches against first and second
    assign cond_a = (ea_in == dw_first_in);
    assign cond_b = (ea_in == dw_second_in);
    // and/or combine
    assign dw_cond = dw_ctrl_in[`BWD_CTL_SEL] ? (cond_a || cond_b) : (cond_a && cond_b);
    // loads only when enabled for loads
    assign dw_hit_out = ls_valid_in && dw_ctrl_in[`BWD_CTL_EN] && dw_ctrl_in[`BWD_CTL_LOAD] && is_load_in
        && |(dw_ctrl_in[`BWD_CTL_THR_HI:`BWD_CTL_THR_LO] & ls_thr_in) && dw_cond;
    // masked match and unmasked match
    assign rw_a = ((res_id_in & rw_mask_in) == (rw_value_in & rw_mask_in));
    assign rw_b = (res_id_in == rw_value_in);
    assign rw_hit_out = rs_valid_in && rw_ctrl_in[`BWD_CTL_EN]
        && |(rw_ctrl_in[`BWD_CTL_THR_HI:`BWD_CTL_THR_LO] & rs_thr_in)
        && (rw_ctrl_in[`BWD_CTL_SEL] ? rw_b : rw_a);
endmodule : bwd_comparator
`default_nettype wire

// [rtl/bwd_debug_unit.sv]
// Contract
// - data watchpoint hit loads interrupt data with the access effective address.
// - resource watchpoint hit loads interrupt data with the accessed resource identifier.
// - after debug return, threads set in the hold vector stay stopped.
// - hold vector is eight bits, one per thread, stopping threads outside debug.
// - eight shared scratch words, visible in status and tile config spaces.
// - each instruction breakpoint holds a target; a met condition raises debug.
// - four independent instruction breakpoints with own address and control.
// - control bits 23:16 are a per-thread enable mask.
// - instruction control bit 1 picks equal or not-equal program counter match.
// - bit 0 enables a comparator; control fields reset to zero.
// - four first comparison addresses for data watchpoints.
// - four second comparison addresses for data watchpoints.
// - data control bit 2 lets the watchpoint trigger on loads.
// - data control bit 1 picks A and B, or A or B.
// - four resource watchpoint mask registers.
// - four resource watchpoint value registers.
// - resource control bit 1 picks condition A or condition B.
// - cause code is 3 instruction, 4 data, 5 resource.
// - on simultaneous hits the lowest number is reported.
`timescale 1ns/1ps
`default_nettype none
module bwd_debug_unit #(
    parameter int NUM_CMP = 4,
    parameter int NUM_THREADS = 8,
    parameter int NUM_SCRATCH = 8
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic debug_mode_in,
    input wire logic ps_wr_in,
    input wire logic ps_rd_in,
    input wire logic [7:0] ps_addr_in,
    input wire logic [31:0] ps_wdata_in,
    output logic [31:0] ps_rdata_out,
    input wire logic cfg_wr_in,
    input wire logic [2:0] cfg_idx_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    input wire logic pc_valid_in,
    input wire logic [31:0] pc_in,
    input wire logic [2:0] pc_thread_in,
    input wire logic ls_valid_in,
    input wire logic ls_load_in,
    input wire logic [31:0] ls_addr_in,
    input wire logic [2:0] ls_thread_in,
    input wire logic rs_valid_in,
    input wire logic [31:0] rs_id_in,
    input wire logic [2:0] rs_thread_in,
    output logic debug_irq_out,
    output bwd_pkg::bwd_cause_t cause_out,
    output logic [1:0] cmp_num_out,
    output logic [7:0] cause_thread_out,
    output logic [31:0] irq_data_out,
    output logic [7:0] thread_stop_out
);
    import bwd_pkg::*;
    `include "bwd_defines.svh"

    bwd_word_t scratch [NUM_SCRATCH];
    bwd_word_t ib_target [NUM_CMP];
    bwd_word_t ib_ctrl [NUM_CMP];
    bwd_word_t dw_first [NUM_CMP];
    bwd_word_t dw_second [NUM_CMP];
    bwd_word_t dw_ctrl [NUM_CMP];
    bwd_word_t rw_mask [NUM_CMP];
    bwd_word_t rw_value [NUM_CMP];
    bwd_word_t rw_ctrl [NUM_CMP];
    bwd_word_t irq_data;
    logic [7:0] core_hold;
    bwd_cause_t cause;
    logic [1:0] cmp_num;
    logic [7:0] cause_thread;
    logic irq_pend;
    logic [NUM_CMP-1:0] ib_hit;
    logic [NUM_CMP-1:0] dw_hit;
    logic [NUM_CMP-1:0] rw_hit;
    logic ib_any;
    logic dw_any;
    logic rw_any;
    logic [1:0] ib_idx;
    logic [1:0] dw_idx;
    logic [1:0] rw_idx;
    logic wr_ok;
    logic [7:0] pc_thr;
    logic [7:0] ls_thr;
    logic [7:0] rs_thr;
    logic in_window;
    bwd_hit_state_t state;
    bwd_hit_state_t next_state;

    // debug write gating, status reads are not gated by mode
    assign wr_ok = ps_wr_in && debug_mode_in;
    assign pc_thr = 8'h01 << pc_thread_in;
    assign ls_thr = 8'h01 << ls_thread_in;
    assign rs_thr = 8'h01 << rs_thread_in;

    // four comparator slots
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++)
        begin : g_slot
            bwd_comparator u_cmp (
                .ib_target_in(ib_target[g]),
                .ib_ctrl_in(ib_ctrl[g]),
                .pc_in(pc_in),
                .dw_first_in(dw_first[g]),
                .dw_second_in(dw_second[g]),
                .dw_ctrl_in(dw_ctrl[g]),
                .ea_in(ls_addr_in),
                .is_load_in(ls_load_in),
                .rw_mask_in(rw_mask[g]),
                .rw_value_in(rw_value[g]),
                .rw_ctrl_in(rw_ctrl[g]),
                .res_id_in(rs_id_in),
                .ib_thr_in(pc_thr),
                .ls_thr_in(ls_thr),
                .rs_thr_in(rs_thr),
                .pc_valid_in(pc_valid_in),
                .ls_valid_in(ls_valid_in),
                .rs_valid_in(rs_valid_in),
                .ib_hit_out(ib_hit[g]),
                .dw_hit_out(dw_hit[g]),
                .rw_hit_out(rw_hit[g])
            );
        end
    endgenerate

    // lowest number wins
    bwd_first_hit #(.N(NUM_CMP)) u_ib_pick (.req_in(ib_hit), .any_out(ib_any), .idx_out(ib_idx));
    bwd_first_hit #(.N(NUM_CMP)) u_dw_pick (.req_in(dw_hit), .any_out(dw_any), .idx_out(dw_idx));
    bwd_first_hit #(.N(NUM_CMP)) u_rw_pick (.req_in(rw_hit), .any_out(rw_any), .idx_out(rw_idx));

    // comparator register writes, controls reset to zero
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                ib_target[i] <= 32'h0000_0000;
                ib_ctrl[i] <= `BWD_CTL_RST;
                dw_first[i] <= 32'h0000_0000;
                dw_second[i] <= 32'h0000_0000;
                dw_ctrl[i] <= `BWD_CTL_RST;
                rw_mask[i] <= 32'h0000_0000;
                rw_value[i] <= 32'h0000_0000;
                rw_ctrl[i] <= `BWD_CTL_RST;
            end
        end
        else if (wr_ok)
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                if (ps_addr_in == `BWD_REG_IBRK_ADDR + 8'(i)) ib_target[i] <= ps_wdata_in;
                if (ps_addr_in == `BWD_REG_IBRK_CTRL + 8'(i)) ib_ctrl[i] <= ps_wdata_in & `BWD_IBRK_CTL_MASK;
                if (ps_addr_in == `BWD_REG_DW_ADDR1 + 8'(i)) dw_first[i] <= ps_wdata_in;
                if (ps_addr_in == `BWD_REG_DW_ADDR2 + 8'(i)) dw_second[i] <= ps_wdata_in;
                if (ps_addr_in == `BWD_REG_DW_CTRL + 8'(i)) dw_ctrl[i] <= ps_wdata_in & `BWD_DW_CTL_MASK;
                if (ps_addr_in == `BWD_REG_RW_MASK + 8'(i)) rw_mask[i] <= ps_wdata_in;
                if (ps_addr_in == `BWD_REG_RW_VALUE + 8'(i)) rw_value[i] <= ps_wdata_in;
                if (ps_addr_in == `BWD_REG_RW_CTRL + 8'(i)) rw_ctrl[i] <= ps_wdata_in & `BWD_RW_CTL_MASK;
            end
        end
    end

    // shared scratch, config side writes regardless of mode
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            for (int i = 0; i < NUM_SCRATCH; i++)
            begin
                scratch[i] <= 32'h0000_0000;
            end
        end
        else if (wr_ok && ps_addr_in[7:3] == `BWD_REG_SCRATCH >> 3)
        begin
            scratch[ps_addr_in[2:0]] <= ps_wdata_in;
        end
        else if (cfg_wr_in)
        begin
            scratch[cfg_idx_in] <= cfg_wdata_in;
        end
    end

    // hold vector
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            core_hold <= 8'h00;
        end
        else if (wr_ok && ps_addr_in == `BWD_REG_CORE_HOLD)
        begin
            core_hold <= ps_wdata_in[7:0];
        end
    end

    // held threads stop once debug mode is left
    assign thread_stop_out = debug_mode_in ? 8'h00 : core_hold;

    // trigger capture sequencer: one report per debug entry
    always_comb
    begin
        next_state = state;
        unique case (state)
            BWD_HIT_NONE:
            begin
                if (!debug_mode_in && (ib_any || dw_any || rw_any))
                begin
                    next_state = BWD_HIT_CAPTURE;
                end
            end
            BWD_HIT_CAPTURE:
            begin
                next_state = BWD_HIT_WAIT;
            end
            BWD_HIT_WAIT:
            begin
                if (debug_mode_in)
                begin
                    next_state = BWD_HIT_NONE;
                end
            end
            default:
            begin
                next_state = BWD_HIT_NONE;
            end
        endcase
    end

    assign in_window = (state == BWD_HIT_NONE) && !debug_mode_in;

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state <= BWD_HIT_NONE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // cause, number, thread and data capture
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cause <= 3'h0;
            cmp_num <= 2'h0;
            cause_thread <= 8'h00;
            irq_data <= 32'h0000_0000;
        end
        else if (in_window && ib_any)
        begin
            cause <= `BWD_CAUSE_IBRK;
            cmp_num <= ib_idx;
            cause_thread <= {5'h00, pc_thread_in};
        end
        else if (in_window && dw_any)
        begin
            cause <= `BWD_CAUSE_DW;
            cmp_num <= dw_idx;
            cause_thread <= {5'h00, ls_thread_in};
            irq_data <= ls_addr_in;
        end
        else if (in_window && rw_any)
        begin
            cause <= `BWD_CAUSE_RW;
            cmp_num <= rw_idx;
            cause_thread <= {5'h00, rs_thread_in};
            irq_data <= rs_id_in;
        end
        else if (wr_ok && ps_addr_in == `BWD_REG_IRQ_DATA)
        begin
            irq_data <= ps_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            irq_pend <= 1'b0;
        end
        else
        begin
            irq_pend <= in_window && (ib_any || dw_any || rw_any);
        end
    end

    assign debug_irq_out = irq_pend;
    assign cause_out = cause;
    assign cmp_num_out = cmp_num;
    assign cause_thread_out = cause_thread;
    assign irq_data_out = irq_data;
    assign cfg_rdata_out = scratch[cfg_idx_in];

    // status-space read mux
    always_comb
    begin
        ps_rdata_out = 32'h0000_0000;
        if (ps_rd_in)
        begin
            if (ps_addr_in == `BWD_REG_IRQ_DATA) ps_rdata_out = irq_data;
            if (ps_addr_in == `BWD_REG_IRQ_TYPE) ps_rdata_out = {14'h0000, cmp_num, cause_thread, 5'h00, cause};
            if (ps_addr_in == `BWD_REG_CORE_HOLD) ps_rdata_out = {24'h00_0000, core_hold};
            if (ps_addr_in[7:3] == 5'(`BWD_REG_SCRATCH >> 3)) ps_rdata_out = scratch[ps_addr_in[2:0]];
            for (int i = 0; i < NUM_CMP; i++)
            begin
                if (ps_addr_in == `BWD_REG_IBRK_ADDR + 8'(i)) ps_rdata_out = ib_target[i];
                if (ps_addr_in == `BWD_REG_IBRK_CTRL + 8'(i)) ps_rdata_out = ib_ctrl[i];
                if (ps_addr_in == `BWD_REG_DW_ADDR1 + 8'(i)) ps_rdata_out = dw_first[i];
                if (ps_addr_in == `BWD_REG_DW_ADDR2 + 8'(i)) ps_rdata_out = dw_second[i];
                if (ps_addr_in == `BWD_REG_DW_CTRL + 8'(i)) ps_rdata_out = dw_ctrl[i];
                if (ps_addr_in == `BWD_REG_RW_MASK + 8'(i)) ps_rdata_out = rw_mask[i];
                if (ps_addr_in == `BWD_REG_RW_VALUE + 8'(i)) ps_rdata_out = rw_value[i];
                if (ps_addr_in == `BWD_REG_RW_CTRL + 8'(i)) ps_rdata_out = rw_ctrl[i];
            end
        end
    end

    // checks
    a_dw_data_load: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (in_window && !ib_any && dw_any) |=> (irq_data == $past(ls_addr_in) && cause == 3'h4))
        else $error("data hit did not capture address");
    a_rw_data_load: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (in_window && !ib_any && !dw_any && rw_any) |=> (irq_data == $past(rs_id_in) && cause == 3'h5))
        else $error("resource hit did not capture id");
    a_hold_stops: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !debug_mode_in |-> thread_stop_out == core_hold)
        else $error("held thread not stopped");
    a_hold_free: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        debug_mode_in |-> thread_stop_out == 8'h00)
        else $error("thread stopped in debug mode");
    a_scratch_shared: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (cfg_wr_in && !(wr_ok && ps_addr_in[7:3] == 5'h04)) |=> scratch[$past(cfg_idx_in)] == $past(cfg_wdata_in))
        else $error("config scratch write lost");
    a_ib_cause: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (in_window && ib_any) |=> (cause == 3'h3 && cmp_num == $past(ib_idx) && debug_irq_out))
        else $error("instruction hit cause wrong");
    a_lowest_wins: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (in_window && ib_hit[0]) |=> cmp_num == 2'h0)
        else $error("lowest breakpoint not reported");
    a_disabled_quiet: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !ib_ctrl[0][0] |-> !ib_hit[0])
        else $error("disabled breakpoint fired");
    a_no_write_outside: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (!debug_mode_in && ps_wr_in) |=> $stable(core_hold))
        else $error("write accepted outside debug");
    a_thread_gate: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !ib_ctrl[0][16 + pc_thread_in] |-> !ib_hit[0])
        else $error("breakpoint fired for masked thread");
    c_ib_hit: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) in_window && ib_any);
    c_dw_hit: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) in_window && dw_any && !ib_any);
    c_rw_hit: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) in_window && rw_any);
    c_hold_step: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $fell(debug_mode_in) && |core_hold);
endmodule : bwd_debug_unit
`default_nettype wire

// [testbench/bwd_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// pipeline side: issues accesses, enters debug mode on interrupt
module bwd_core_model #(
    parameter int ENTER_LAT = 1
) (
    input wire logic clk_sys_in,
    input wire logic debug_irq_in,
    output logic debug_mode_out,
    output logic pc_valid_out,
    output logic [31:0] pc_out,
    output logic [2:0] pc_thread_out,
    output logic ls_valid_out,
    output logic ls_load_out,
    output logic [31:0] ls_addr_out,
    output logic [2:0] ls_thread_out,
    output logic rs_valid_out,
    output logic [31:0] rs_id_out,
    output logic [2:0] rs_thread_out
);
    initial
    begin
        debug_mode_out = 1'b1;
        {rs_valid_out, ls_valid_out, pc_valid_out, ls_load_out} = 4'h0;
        {pc_out, ls_addr_out, rs_id_out} = '0;
        {pc_thread_out, ls_thread_out, rs_thread_out} = '0;
    end
    // debug entry some cycles after the interrupt pulse
    always @(posedge clk_sys_in)
    begin
        if (debug_irq_in === 1'b1)
        begin
            repeat (ENTER_LAT - 1) @(posedge clk_sys_in);
            #1 debug_mode_out = 1'b1;
        end
    end
    task automatic set_debug(input logic m);
        @(posedge clk_sys_in);
        #1 debug_mode_out = m;
    endtask : set_debug
    // one issue cycle on the chosen paths, then the lines scramble
    task automatic fire(input logic [2:0] k, input logic [31:0] v, input logic [2:0] t, input logic ld);
        @(posedge clk_sys_in);
        #1 {rs_valid_out, ls_valid_out, pc_valid_out} = k;
        ls_load_out = ld;
        {pc_out, ls_addr_out, rs_id_out} = {v, v, v};
        {pc_thread_out, ls_thread_out, rs_thread_out} = {t, t, t};
        @(posedge clk_sys_in);
        #1 {rs_valid_out, ls_valid_out, pc_valid_out} = 3'h0;
        ls_load_out = ~ld;
        {pc_out, ls_addr_out, rs_id_out} = {~v, ~v, ~v};
        {pc_thread_out, ls_thread_out, rs_thread_out} = {~t, ~t, ~t};
    endtask : fire
endmodule : bwd_core_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bwd_defines.svh"
module tb_top;
    import bwd_pkg::*;
    localparam logic [7:0] BASE [8] = '{8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h9c};
    localparam logic [31:0] MSK [8] = '{32'hffff_ffff, `BWD_IBRK_CTL_MASK, 32'hffff_ffff, 32'hffff_ffff,
        `BWD_DW_CTL_MASK, 32'hffff_ffff, 32'hffff_ffff, `BWD_RW_CTL_MASK};
    logic clk_sys_in = 1'b0, arst_n_in = 1'b0, debug_mode_in, ps_wr_in = 1'b0, ps_rd_in = 1'b0, cfg_wr_in = 1'b0;
    logic [7:0] ps_addr_in = 8'h0;
    logic [31:0] ps_wdata_in = 32'h0, cfg_wdata_in = 32'h0, ps_rdata_out, cfg_rdata_out, pc_in, ls_addr_in, rs_id_in;
    logic [2:0] cfg_idx_in = 3'h0, pc_thread_in, ls_thread_in, rs_thread_in;
    logic pc_valid_in, ls_valid_in, ls_load_in, rs_valid_in, debug_irq_out;
    bwd_cause_t cause_out;
    logic [1:0] cmp_num_out;
    logic [7:0] cause_thread_out, thread_stop_out;
    logic [31:0] irq_data_out, r;
    logic [45:0] exp_q [$];
    logic [45:0] e, g;
    int err_count = 0, n_checks = 0;
    bwd_debug_unit u_bwd_debug_unit (.clk_sys_in, .arst_n_in, .debug_mode_in, .ps_wr_in, .ps_rd_in, .ps_addr_in,
        .ps_wdata_in, .ps_rdata_out, .cfg_wr_in, .cfg_idx_in, .cfg_wdata_in, .cfg_rdata_out, .pc_valid_in, .pc_in,
        .pc_thread_in, .ls_valid_in, .ls_load_in, .ls_addr_in, .ls_thread_in, .rs_valid_in, .rs_id_in,
        .rs_thread_in, .debug_irq_out, .cause_out, .cmp_num_out, .cause_thread_out, .irq_data_out, .thread_stop_out);
    bwd_core_model u_bwd_core_model (.clk_sys_in(clk_sys_in), .debug_irq_in(debug_irq_out),
        .debug_mode_out(debug_mode_in), .pc_valid_out(pc_valid_in), .pc_out(pc_in), .pc_thread_out(pc_thread_in),
        .ls_valid_out(ls_valid_in), .ls_load_out(ls_load_in), .ls_addr_out(ls_addr_in),
        .ls_thread_out(ls_thread_in), .rs_valid_out(rs_valid_in), .rs_id_out(rs_id_in),
        .rs_thread_out(rs_thread_in));
    initial
    begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [45:0] got, input logic [45:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        #1 {ps_wr_in, ps_addr_in, ps_wdata_in} = {1'b1, a, d};
        @(posedge clk_sys_in);
        #1 ps_wr_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        #1 {ps_rd_in, ps_addr_in} = {1'b1, a};
        @(posedge clk_sys_in);
        chk({14'h0, ps_rdata_out}, {14'h0, d}, "read");
        #1 ps_rd_in = 1'b0;
    endtask : rd
    task automatic arm(input logic [7:0] a, input logic [31:0] d);
        u_bwd_core_model.set_debug(1'b1);
        wr(a, d);
        u_bwd_core_model.set_debug(1'b0);
    endtask : arm
    task automatic note_hit(input logic [2:0] c, input logic [1:0] n, input logic [2:0] t, input logic [31:0] d);
        exp_q.push_back({c != `BWD_CAUSE_IBRK, c, n, 5'h0, t, d});
    endtask : note_hit
    task automatic miss(input logic [2:0] k, input logic [31:0] v, input logic [2:0] t, input logic ld);
        u_bwd_core_model.fire(k, v, t, ld);
        repeat (4) @(posedge clk_sys_in);
    endtask : miss
    task automatic hit(input logic [2:0] k, input logic [31:0] v, input logic [2:0] t, input logic ld);
        int i;
        u_bwd_core_model.fire(k, v, t, ld);
        for (i = 0; i < 20 && debug_mode_in !== 1'b1; i++)
            @(posedge clk_sys_in);
        chk({45'h0, debug_mode_in}, 46'h1, "no interrupt");
        if (debug_mode_in !== 1'b1)
            wrap_up();
        else
            u_bwd_core_model.set_debug(1'b0);
    endtask : hit
    // scoreboard: oldest expected interrupt against the captured outputs
    always @(negedge clk_sys_in)
    begin
        if (debug_irq_out === 1'b1)
        begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
            g = {e[45], cause_out, cmp_num_out, cause_thread_out, e[45] ? irq_data_out : e[31:0]};
            chk(g, e, "interrupt");
        end
    end
    initial
    begin
        void'($urandom(25));
        repeat (6) @(posedge clk_sys_in);
        #1 arst_n_in = 1'b1;
        for (int i = 0; i < 4; i++)
            rd(8'h40 + 8'(i), 32'h0);
        for (int i = 0; i < 4; i++)
            rd(8'h70 + 8'(i), 32'h0);
        for (int i = 0; i < 4; i++)
            rd(8'h9c + 8'(i), 32'h0);
        for (int j = 0; j < 8; j++)
            for (int i = 0; i < 4; i++)
            begin
                r = $urandom;
                wr(BASE[j] + 8'(i), r);
                rd(BASE[j] + 8'(i), r & MSK[j]);
                wr(BASE[j] + 8'(i), 32'h0);
            end
        r = $urandom;
        wr(`BWD_REG_IRQ_DATA, r);
        rd(`BWD_REG_IRQ_DATA, r);
        rd(8'h17, 32'h0);
        u_bwd_core_model.set_debug(1'b0);
        wr(8'h31, r);
        u_bwd_core_model.set_debug(1'b1);
        rd(8'h31, 32'h0);
        $display("test registers done");
        @(posedge clk_sys_in);
        #1 {cfg_wr_in, cfg_idx_in, cfg_wdata_in} = {1'b1, 3'h3, r};
        @(posedge clk_sys_in);
        #1 cfg_wr_in = 1'b0;
        rd(8'h23, r);
        wr(8'h26, ~r);
        cfg_idx_in = 3'h6;
        #1 chk({14'h0, cfg_rdata_out}, {14'h0, ~r}, "scratch");
        wr(`BWD_REG_CORE_HOLD, 32'hffff_ffa5);
        rd(`BWD_REG_CORE_HOLD, 32'h0000_00a5);
        chk({38'h0, thread_stop_out}, 46'h0, "stop in debug");
        u_bwd_core_model.set_debug(1'b0);
        #1 chk({38'h0, thread_stop_out}, 46'ha5, "stop after return");
        arm(`BWD_REG_CORE_HOLD, 32'h0);
        $display("test scratch and hold done");
        r = $urandom;
        arm(8'h33, r);
        arm(8'h43, 32'h0020_0000);
        miss(3'h1, r, 3'h5, 1'b0);
        arm(8'h43, 32'h0020_0001);
        miss(3'h1, r, 3'h4, 1'b0);
        note_hit(`BWD_CAUSE_IBRK, 2'h3, 3'h5, 32'h0);
        hit(3'h1, r, 3'h5, 1'b0);
        arm(8'h43, 32'h0020_0003);
        miss(3'h1, r, 3'h5, 1'b0);
        note_hit(`BWD_CAUSE_IBRK, 2'h3, 3'h5, 32'h0);
        hit(3'h1, r ^ 32'h4, 3'h5, 1'b0);
        arm(8'h43, 32'h0);
        $display("test instruction done");
        arm(8'h51, r);
        arm(8'h61, ~r);
        arm(8'h71, 32'h0001_0005);
        miss(3'h2, r, 3'h0, 1'b1);
        arm(8'h71, 32'h0001_0007);
        miss(3'h2, r, 3'h0, 1'b0);
        note_hit(`BWD_CAUSE_DW, 2'h1, 3'h0, ~r);
        hit(3'h2, ~r, 3'h0, 1'b1);
        arm(8'h71, 32'h0001_0003);
        miss(3'h2, r, 3'h0, 1'b1);
        arm(8'h71, 32'h0);
        $display("test data done");
        arm(8'h82, 32'h0000_ff00);
        arm(8'h92, 32'h0000_1234);
        arm(8'h9e, 32'h0002_0001);
        note_hit(`BWD_CAUSE_RW, 2'h2, 3'h1, 32'h12ff);
        hit(3'h4, 32'h12ff, 3'h1, 1'b0);
        arm(8'h9e, 32'h0002_0003);
        miss(3'h4, 32'h12ff, 3'h1, 1'b0);
        note_hit(`BWD_CAUSE_RW, 2'h2, 3'h1, 32'h1234);
        hit(3'h4, 32'h1234, 3'h1, 1'b0);
        arm(8'h9e, 32'h0);
        $display("test resource done");
        arm(8'h31, r);
        arm(8'h32, r);
        arm(8'h42, 32'h0080_0001);
        arm(8'h41, 32'h0080_0001);
        note_hit(`BWD_CAUSE_IBRK, 2'h1, 3'h7, 32'h0);
        hit(3'h1, r, 3'h7, 1'b0);
        rd(`BWD_REG_IRQ_TYPE, 32'h0001_0703);
        rd(`BWD_REG_IRQ_DATA, 32'h0000_1234);
        $display("test priority done");
        repeat (4) @(posedge clk_sys_in);
        chk(46'(exp_q.size()), 46'h0, "pending interrupts");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
